// file: verilog/iab_pkg.sv
package iab_pkg;

  // Register byte offsets on the bus, one aligned word each
  localparam logic [4:0] IAB_OFS_STATUS = 5'h00;
  localparam logic [4:0] IAB_OFS_CTRL1 = 5'h04;
  localparam logic [4:0] IAB_OFS_CTRL2 = 5'h08;
  localparam logic [4:0] IAB_OFS_CTRL3 = 5'h0C;
  localparam logic [4:0] IAB_OFS_MASK = 5'h10;
  localparam logic [4:0] IAB_OFS_ADDR = 5'h14;
  localparam logic [4:0] IAB_OFS_BUF = 5'h18;

  // Reset values
  localparam logic [7:0] IAB_RST_CTRL = 8'h00;
  localparam logic [7:0] IAB_RST_MASK = 8'hFF;
  localparam logic [7:0] IAB_RST_ADDR = 8'h00;

  // Field positions
  localparam int IAB_CTRL1_EN_BIT = 5;
  localparam int IAB_ST_MATCH_BIT = 0;
  localparam int IAB_ST_HIGH_BIT = 1;
  localparam int IAB_ST_SCL_BIT = 2;
  localparam int IAB_ST_HOST_BIT = 3;

  // Port mode select encodings
  localparam logic [3:0] IAB_MODE_CLIENT7 = 4'h6;
  localparam logic [3:0] IAB_MODE_CLIENT10 = 4'h7;
  localparam logic [3:0] IAB_MODE_HOST = 4'h8;
  localparam logic [3:0] IAB_MODE_CLIENT7_SP = 4'hE;
  localparam logic [3:0] IAB_MODE_CLIENT10_SP = 4'hF;

  // Fixed prefix of the high address byte in 10-bit addressing
  localparam logic [4:0] IAB_TEN_BIT_PREFIX = 5'h1E;

  // Serial clock period is this many oscillator cycles per divider step
  localparam int IAB_SCL_CYCLES_PER_STEP = 4;
  localparam logic [9:0] IAB_SCL_HALF_STEP = 10'(IAB_SCL_CYCLES_PER_STEP / 2);

  typedef enum logic [1:0] {
    IAB_BUS_IDLE = 2'b01,
    IAB_BUS_ACK = 2'b10
  } iab_bus_state_t;

  // Byte received from the shift logic of the port
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } iab_rx_t;

  typedef struct packed {
    iab_bus_state_t bus;
    logic [31:0] rdata;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:0] mask;
    logic [7:0] addr;
    logic matched;
    logic high_ok;
    logic match_pulse;
    logic [9:0] scl_cnt;
    logic scl;
  } iab_state_t;

endpackage

// file: verilog/iab_byte_store.sv
`timescale 1ns/100ps
`default_nettype none

// Holds its content across resets: deliberately no reset input
module iab_byte_store
  import iab_pkg::*;
(
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);

  logic [7:0] mem_reg;

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem_reg <= wr_data;
    end
    rd_data <= mem_reg;
  end

endmodule

`default_nettype wire

// file: verilog/iab_addr_baud.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [R1] Host mode serial clock period is four times divider plus one oscillator cycles.
// [R2] High 10-bit address byte must carry prefix 11110; hardware checks it, ignores register bits 7-3.
// [R3] High 10-bit byte compares register bits 2-1 as top address bits; bit 0 ignored.
// [R4] Low 10-bit byte compares all eight register bits against received byte.
// [R5] 7-bit client address is register bits 7-1; bit 0 is don't-care.
// [R6] Eight-bit software buffer carries bytes; undefined at power-up, kept across resets.
// [R7] Received address bits 7-1 take part only where the mask bit is one.
// [R8] Software must not load divider values 0, 1 or 2 in bus mode.
// [R9] 10-bit match declared only after high byte then low byte both match.
module iab_addr_baud
  import iab_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire iab_rx_t rx_in,
  output logic addr_match,
  output logic scl_clk,
  output logic [3:0] port_mode_select,
  output logic port_enable
);

  iab_state_t st_reg;
  iab_state_t st_next;
  logic [7:0] buf_rdata;
  logic buf_wr;
  logic [7:0] buf_wdata;
  logic bus_req;
  logic bus_take;
  logic mode_c7;
  logic mode_c10;
  logic mode_host;
  logic [9:0] scl_half;

  // True when every masked bit of the received byte equals the stored one
  function automatic logic masked_eq(input logic [7:0] rx, input logic [7:0] own,
                                     input logic [7:0] msk);
    masked_eq = (((rx ^ own) & msk) == 8'h00);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [4:0] a, input iab_state_t s,
                                         input logic [7:0] bdata);
    logic [7:0] stat;
    stat = 8'h00;
    stat[IAB_ST_MATCH_BIT] = s.matched;
    stat[IAB_ST_HIGH_BIT] = s.high_ok;
    stat[IAB_ST_SCL_BIT] = s.scl;
    stat[IAB_ST_HOST_BIT] = (s.ctrl1[3:0] == IAB_MODE_HOST);
    unique case (a)
      IAB_OFS_STATUS: rd_mux = {24'h000000, stat};
      IAB_OFS_CTRL1: rd_mux = {24'h000000, s.ctrl1};
      IAB_OFS_CTRL2: rd_mux = {24'h000000, s.ctrl2};
      IAB_OFS_CTRL3: rd_mux = {24'h000000, s.ctrl3};
      IAB_OFS_MASK: rd_mux = {24'h000000, s.mask};
      IAB_OFS_ADDR: rd_mux = {24'h000000, s.addr};
      IAB_OFS_BUF: rd_mux = {24'h000000, bdata};
      default: rd_mux = 32'h00000000;
    endcase
  endfunction

  assign bus_req = read | write;
  assign bus_take = (st_reg.bus == IAB_BUS_ACK) & bus_req;
  assign waitrequest = ~(st_reg.bus == IAB_BUS_ACK);
  assign readdata = st_reg.rdata;
  assign addr_match = st_reg.match_pulse;
  assign scl_clk = st_reg.scl;
  assign port_mode_select = st_reg.ctrl1[3:0];
  assign port_enable = st_reg.ctrl1[IAB_CTRL1_EN_BIT];

  assign mode_c7 = port_enable &
    ((port_mode_select == IAB_MODE_CLIENT7) | (port_mode_select == IAB_MODE_CLIENT7_SP));
  assign mode_c10 = port_enable &
    ((port_mode_select == IAB_MODE_CLIENT10) | (port_mode_select == IAB_MODE_CLIENT10_SP));
  assign mode_host = port_enable & (port_mode_select == IAB_MODE_HOST);

  // Half of the period: (divider + 1) * 4 / 2 cycles
  assign scl_half = (10'(st_reg.addr) + 10'h001) * IAB_SCL_HALF_STEP; // [R1]

  // A received byte takes priority over a bus write in the same cycle
  assign buf_wr = rx_in.valid | (bus_take & write & (address == IAB_OFS_BUF)); // [R6]
  assign buf_wdata = rx_in.valid ? rx_in.data : writedata[7:0];

  iab_byte_store u_buf (
    .clock(clock),
    .wr_en(buf_wr),
    .wr_data(buf_wdata),
    .rd_data(buf_rdata)
  );

  always_comb
  begin
    st_next = st_reg;
    st_next.match_pulse = 1'b0;

    unique case (st_reg.bus)
      IAB_BUS_IDLE:
      begin
        if (bus_req)
        begin
          st_next.bus = IAB_BUS_ACK;
          st_next.rdata = read ? rd_mux(address, st_reg, buf_rdata) : 32'h00000000;
        end
      end
      IAB_BUS_ACK:
      begin
        st_next.bus = IAB_BUS_IDLE;
      end
      default:
      begin
        st_next.bus = IAB_BUS_IDLE;
      end
    endcase

    if (bus_take & write)
    begin
      unique case (address)
        IAB_OFS_STATUS:
        begin
          if (writedata[IAB_ST_MATCH_BIT])
          begin
            st_next.matched = 1'b0;
          end
        end
        IAB_OFS_CTRL1: st_next.ctrl1 = writedata[7:0];
        IAB_OFS_CTRL2: st_next.ctrl2 = writedata[7:0];
        IAB_OFS_CTRL3: st_next.ctrl3 = writedata[7:0];
        IAB_OFS_MASK: st_next.mask = writedata[7:0];
        // Values 0..2 are not trapped; software keeps out of them
        IAB_OFS_ADDR: st_next.addr = writedata[7:0]; // [R8]
        default:
        begin
        end
      endcase
    end

    // Address compare on received bytes; set wins over the software clear
    if (rx_in.valid)
    begin
      if (mode_c7 & rx_in.first)
      begin
        if (masked_eq(rx_in.data, st_reg.addr, {st_reg.mask[7:1], 1'b0})) // [R5] [R7]
        begin
          st_next.matched = 1'b1;
          st_next.match_pulse = 1'b1;
        end
      end
      else if (mode_c10 & rx_in.first)
      begin
        // Only bits 2-1 come from the register; the prefix is fixed
        st_next.high_ok = (rx_in.data[7:3] == IAB_TEN_BIT_PREFIX) & // [R2]
          masked_eq({5'h00, rx_in.data[2:1], 1'b0}, {5'h00, st_reg.addr[2:1], 1'b0},
                    {5'h00, st_reg.mask[2:1], 1'b0}); // [R3] [R7]
      end
      else if (mode_c10 & st_reg.high_ok)
      begin
        st_next.high_ok = 1'b0;
        if (masked_eq(rx_in.data, st_reg.addr, st_reg.mask)) // [R4] [R9]
        begin
          st_next.matched = 1'b1;
          st_next.match_pulse = 1'b1;
        end
      end
      else
      begin
        st_next.high_ok = 1'b0;
      end
    end

    if (!mode_c10)
    begin
      st_next.high_ok = 1'b0;
    end

    // Baud generator; the >= guards against a divider lowered mid-count
    if (mode_host)
    begin
      if (st_reg.scl_cnt + 10'h001 >= scl_half) // [R1]
      begin
        st_next.scl_cnt = 10'h000;
        st_next.scl = ~st_reg.scl;
      end
      else
      begin
        st_next.scl_cnt = st_reg.scl_cnt + 10'h001;
      end
    end
    else
    begin
      st_next.scl_cnt = 10'h000;
      st_next.scl = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg.bus <= IAB_BUS_IDLE;
      st_reg.rdata <= 32'h00000000;
      st_reg.ctrl1 <= IAB_RST_CTRL;
      st_reg.ctrl2 <= IAB_RST_CTRL;
      st_reg.ctrl3 <= IAB_RST_CTRL;
      st_reg.mask <= IAB_RST_MASK;
      st_reg.addr <= IAB_RST_ADDR;
      st_reg.matched <= 1'b0;
      st_reg.high_ok <= 1'b0;
      st_reg.match_pulse <= 1'b0;
      st_reg.scl_cnt <= 10'h000;
      st_reg.scl <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// file: test/iab_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module iab_rx_model
  import iab_pkg::*;
(
  input wire logic clock,
  input wire logic go,
  input wire logic first,
  input wire logic [7:0] data,
  output var iab_rx_t rx_in
);
  initial rx_in = '0;
  // Between bytes the data is inverted every cycle, so it alternates between the inverse and the last byte
  always @(posedge clock)
  begin
    rx_in.valid <= go;
    rx_in.first <= first;
    rx_in.data <= go ? data : ~rx_in.data;
  end
endmodule
`default_nettype wire

// file: test/iab_checker.sv
`timescale 1ns/100ps
`default_nettype none
module iab_checker
  import iab_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire iab_rx_t rx_in,
  input wire logic addr_match,
  input wire logic scl_clk,
  input wire logic [3:0] port_mode_select,
  input wire logic port_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_upper; read && !waitrequest |-> readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("read upper bits");
  property p_unmap; read && !waitrequest && address > IAB_OFS_BUF |-> readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_ctrl; write && !waitrequest && address == IAB_OFS_CTRL1
    |=> port_mode_select == $past(writedata[3:0]) && port_enable == $past(writedata[5]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("mode not taken");
  property p_cause; addr_match |-> $past(rx_in.valid) && $past(port_enable); endproperty
  a_cause: assert property (p_cause) else $error("match without byte");
  property p_off; rx_in.valid && !port_enable |=> !addr_match; endproperty
  a_off: assert property (p_off) else $error("match while off");
  property p_idle; (!port_enable) [*2] |-> scl_clk; endproperty
  a_idle: assert property (p_idle) else $error("serial clock not idle");
  c_wr: cover property (write && !waitrequest);
  c_match: cover property (addr_match);
  c_scl: cover property ($fell(scl_clk));
endmodule
bind iab_addr_baud iab_checker u_iab_checker (
  .clock(clock),
  .rstn(rstn),
  .address(address),
  .read(read),
  .write(write),
  .writedata(writedata),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .rx_in(rx_in),
  .addr_match(addr_match),
  .scl_clk(scl_clk),
  .port_mode_select(port_mode_select),
  .port_enable(port_enable)
);
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import iab_pkg::*;
;
  logic clock = 1'h0, rstn = 1'h0, read = 1'h0, write = 1'h0, go = 1'h0, first = 1'h0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [7:0] data = 8'h00;
  logic waitrequest, addr_match, scl_clk, port_enable, m;
  logic [3:0] port_mode_select;
  iab_rx_t rx_in;
  int err_count = 0, n_compared = 0;
  iab_addr_baud u_iab_addr_baud (
    .clock(clock),
    .rstn(rstn),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .rx_in(rx_in),
    .addr_match(addr_match),
    .scl_clk(scl_clk),
    .port_mode_select(port_mode_select),
    .port_enable(port_enable)
  );
  iab_rx_model u_iab_rx_model (
    .clock(clock),
    .go(go),
    .first(first),
    .data(data),
    .rx_in(rx_in)
  );
  initial forever #25 clock = ~clock;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    // Waitrequest and read data are taken as they stand at the rising edge
    @(posedge clock);
    while (waitrequest !== 1'h0)
    begin
      @(posedge clock);
    end
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge clock);
  endtask
  task automatic rx(input logic f, input logic [7:0] d);
    go <= 1'h1;
    first <= f;
    data <= d;
    @(posedge clock);
    go <= 1'h0;
    @(posedge clock);
    @(posedge clock);
    m = addr_match;
  endtask
  task automatic t_regs;
    logic [4:0] a[5] = '{IAB_OFS_CTRL2, IAB_OFS_CTRL3, IAB_OFS_MASK, IAB_OFS_ADDR, IAB_OFS_BUF};
    bus(1'h0, IAB_OFS_MASK, 8'h00);
    chk("mask", 32'hFF, q);
    bus(1'h0, IAB_OFS_ADDR, 8'h00);
    chk("divider", 32'h00, q);
    foreach (a[i])
    begin
      bus(1'h1, a[i], 8'hC3);
      bus(1'h0, a[i], 8'h00);
      chk("reg", 32'hC3, q);
    end
    bus(1'h1, 5'h1C, 8'hFF);
    bus(1'h0, 5'h1C, 8'h00);
    chk("unmapped", 32'h0, q);
    rstn <= 1'h0;
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    bus(1'h0, IAB_OFS_BUF, 8'h00);
    chk("buf kept", 32'hC3, q);
    bus(1'h0, IAB_OFS_MASK, 8'h00);
    chk("mask reset", 32'hFF, q);
    bus(1'h0, IAB_OFS_ADDR, 8'h00);
    chk("divider reset", 32'h00, q);
    $display("regs done");
  endtask
  task automatic t_seven;
    logic [3:0] md[2] = '{IAB_MODE_CLIENT7, IAB_MODE_CLIENT7_SP};
    foreach (md[i])
    begin
      bus(1'h1, IAB_OFS_MASK, 8'hFF);
      bus(1'h1, IAB_OFS_ADDR, 8'hA0);
      bus(1'h1, IAB_OFS_CTRL1, {4'h2, md[i]});
      chk("mode", md[i], port_mode_select);
      chk("enable", 32'h1, port_enable);
      rx(1'h1, 8'hA1);
      chk("match7", 32'h1, m);
      rx(1'h1, 8'hA2);
      chk("miss7", 32'h0, m);
      bus(1'h1, IAB_OFS_MASK, 8'hFD);
      rx(1'h1, 8'hA2);
      chk("masked", 32'h1, m);
      bus(1'h0, IAB_OFS_STATUS, 8'h00);
      chk("status", 32'h05, q);
      bus(1'h1, IAB_OFS_STATUS, 8'h01);
      bus(1'h0, IAB_OFS_STATUS, 8'h00);
      chk("status clear", 32'h04, q);
      bus(1'h0, IAB_OFS_BUF, 8'h00);
      chk("rx buf", 32'hA2, q);
      bus(1'h1, IAB_OFS_CTRL1, {4'h0, md[i]});
      rx(1'h1, 8'hA0);
      chk("off", 32'h0, m);
    end
    $display("seven done");
  endtask
  task automatic t_ten;
    logic [3:0] md[2] = '{IAB_MODE_CLIENT10, IAB_MODE_CLIENT10_SP};
    logic [7:0] hi[4] = '{8'hF7, 8'hE6, 8'hF6, 8'hF2};
    logic [7:0] lo[4] = '{8'h5C, 8'h5C, 8'h5D, 8'h5C};
    logic ex[4] = '{1'h1, 1'h0, 1'h0, 1'h0};
    foreach (md[j])
    begin
      bus(1'h1, IAB_OFS_MASK, 8'hFF);
      bus(1'h1, IAB_OFS_CTRL1, {4'h2, md[j]});
      foreach (hi[i])
      begin
        bus(1'h1, IAB_OFS_ADDR, 8'h06);
        rx(1'h1, hi[i]);
        chk("ten high", 32'h0, m);
        bus(1'h1, IAB_OFS_ADDR, 8'h5C);
        rx(1'h0, lo[i]);
        chk("ten low", ex[i], m);
      end
    end
    $display("ten done");
  endtask
  task automatic t_host;
    logic [7:0] dv[2] = '{8'h03, 8'h04};
    int n;
    foreach (dv[i])
    begin
      bus(1'h1, IAB_OFS_ADDR, dv[i]);
      bus(1'h1, IAB_OFS_CTRL1, {4'h2, IAB_MODE_HOST});
      for (n = 0; n < 99 && scl_clk !== 1'h0; n++) @(negedge clock);
      for (n = 0; n < 99 && scl_clk === 1'h0; n++) @(negedge clock);
      chk("scl low", IAB_SCL_CYCLES_PER_STEP / 2 * (dv[i] + 1), n);
      for (n = 0; n < 99 && scl_clk === 1'h1; n++) @(negedge clock);
      chk("scl high", IAB_SCL_CYCLES_PER_STEP / 2 * (dv[i] + 1), n);
      @(posedge clock);
      bus(1'h1, IAB_OFS_CTRL1, 8'h00);
    end
    $display("host done");
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'h1;
    @(posedge clock);
    t_regs();
    t_seven();
    t_ten();
    t_host();
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
